// File: rtl/lpd_decoder.v
`timescale 1ns/10ps
`include "lpd_map.vh"

// Functional notes
// - E4h higher oscillator, E5h lower oscillator
// - 82h normal mode, 83h partial mode
// - Normal mode: pin duty, ordinary bias
// - Partial mode: loaded partial duty and bias
// - Duty codes 0-4 valid, 5-7 ignored
// - Partial duty/bias ignored in normal mode
// - Duty write also sets matching partial bias
// - Duty above pin maximum held at maximum
// - Bias codes 0-5 valid, 6-7 ignored
// - Commons outside partial area get non-select
// - Start line from low six bits
// - Start beyond pin maximum becomes zero
// - Inversion every low-five-bits plus one lines
// - Inversion applies only after count loaded
// - Duty 1/9 or 1/17 cancels inversion
// - 84h releases inversion to frame inversion
module lpd_decoder (
   input wire clk,
   input wire rst_n,
   input wire cmd_wr_stb,
   input wire command_data_select,
   input wire [7:0] cmd_byte,
   input wire max_duty_select_pin_lo,
   input wire max_duty_select_pin_hi,
   input wire [2:0] normal_bias_code,
   input wire [5:0] scan_line,
   output reg osc_freq_low,
   output reg partial_mode,
   output reg [2:0] display_duty_code,
   output reg [6:0] display_lines,
   output reg [2:0] display_bias_code,
   output reg [5:0] partial_start_line,
   output reg nline_inv_active,
   output reg [4:0] nline_inv_count,
   output reg com_nonselect,
   output reg value_pending
);

   // ----------------------------------------------------------------
   // Prefix tracker states
   // ----------------------------------------------------------------
   localparam ST_IDLE = 2'b00;
   localparam ST_START_VAL = 2'b01;
   localparam ST_NLINE_VAL = 2'b10;

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   wire [1:0] duty_pins;
   wire [2:0] pin_max_code;
   wire [2:0] duty_clamped;
   wire [6:0] pin_max_lines;
   wire [2:0] req_code;
   wire cmd_write;
   reg [1:0] state;
   reg [1:0] next_state;
   reg [2:0] part_duty;
   reg [2:0] part_bias;
   reg [5:0] start_raw;
   reg nline_loaded;
   reg [4:0] nline_cnt;
   reg [2:0] eff_duty;
   reg [6:0] eff_lines;
   reg [2:0] eff_bias;
   reg [5:0] eff_start;
   reg eff_nline;
   reg [6:0] area_end;
   reg eff_nonselect;
   reg below_area;
   reg above_area;
   wire op_osc_hi;
   wire op_osc_lo;
   wire op_mode_normal;
   wire op_mode_partial;
   wire op_release;
   wire op_start_prefix;
   wire op_nline_prefix;
   wire op_duty;
   wire op_bias;
   wire duty_code_ok;
   wire bias_code_ok;
   wire take_start;
   wire take_nline;

   // ----------------------------------------------------------------
   // Helper functions
   // ----------------------------------------------------------------
   // Bias that pairs with each partial duty
   function [2:0] bias_for_duty;
      input [2:0] code;
      begin
         case (code)
            3'h0: bias_for_duty = 3'h0;
            3'h1: bias_for_duty = 3'h1;
            3'h2: bias_for_duty = 3'h2;
            3'h3: bias_for_duty = 3'h3;
            default: bias_for_duty = 3'h4;
         endcase
      end
   endfunction

   function is_group;
      input [7:0] byte_in;
      input [4:0] grp;
      begin
         is_group = (byte_in[`LPD_GRP_HI:`LPD_GRP_LO] == grp);
      end
   endfunction

   function [6:0] lines_of;
      input [2:0] code;
      begin
         case (code)
            3'h0: lines_of = 7'h08;
            3'h1: lines_of = 7'h10;
            3'h2: lines_of = 7'h20;
            3'h3: lines_of = 7'h30;
            default: lines_of = 7'h40;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Strap pins and duty limit
   // ----------------------------------------------------------------
   // Straps come from pads, so they cross into the clock domain
   lpd_pin_sync #(
      .WIDTH(2)
   ) u_pin_sync (
      .clk(clk),
      .rst_n(rst_n),
      .pin({max_duty_select_pin_hi, max_duty_select_pin_lo}),
      .level(duty_pins)
   );

   assign req_code = cmd_byte[`LPD_CODE_HI:0];

   lpd_duty_limit u_duty_limit (
      .duty_pins(duty_pins),
      .req_code(req_code),
      .max_code(pin_max_code),
      .clamped_code(duty_clamped),
      .max_lines(pin_max_lines)
   );

   // ----------------------------------------------------------------
   // Command qualification
   // ----------------------------------------------------------------
   // Data writes (select high) belong to the RAM path
   assign cmd_write = cmd_wr_stb & ~command_data_select;

   // ----------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------
   // Opcodes only count outside a pending pair, so a value byte that
   // happens to look like an opcode is never acted on as one
   assign op_osc_hi = (state == ST_IDLE) && (cmd_byte == `LPD_OP_OSC_HI);
   assign op_osc_lo = (state == ST_IDLE) && (cmd_byte == `LPD_OP_OSC_LO);
   assign op_mode_normal = (state == ST_IDLE) && (cmd_byte == `LPD_OP_MODE_NORMAL);
   assign op_mode_partial = (state == ST_IDLE) && (cmd_byte == `LPD_OP_MODE_PARTIAL);
   assign op_release = (state == ST_IDLE) && (cmd_byte == `LPD_OP_NLINE_RELEASE);
   assign op_start_prefix = (state == ST_IDLE) && (cmd_byte == `LPD_OP_START_PREFIX);
   assign op_nline_prefix = (state == ST_IDLE) && (cmd_byte == `LPD_OP_NLINE_PREFIX);
   assign op_duty = (state == ST_IDLE) && is_group(cmd_byte, `LPD_GRP_DUTY);
   assign op_bias = (state == ST_IDLE) && is_group(cmd_byte, `LPD_GRP_BIAS);

   // Reserved codes are dropped rather than clamped
   assign duty_code_ok = (req_code <= `LPD_DUTY_LAST);
   assign bias_code_ok = (req_code <= `LPD_BIAS_LAST);

   assign take_start = (state == ST_START_VAL);
   assign take_nline = (state == ST_NLINE_VAL);

   // ----------------------------------------------------------------
   // Prefix tracker
   // ----------------------------------------------------------------
   always @* begin
      next_state = state;
      if (cmd_write) begin
         case (state)
            ST_IDLE: begin
               if (cmd_byte == `LPD_OP_START_PREFIX) begin
                  next_state = ST_START_VAL;
               end else if (cmd_byte == `LPD_OP_NLINE_PREFIX) begin
                  next_state = ST_NLINE_VAL;
               end
            end
            default: begin
               next_state = ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ----------------------------------------------------------------
   // Setting registers
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         osc_freq_low <= `LPD_RST_OSC_LOW;
         partial_mode <= `LPD_RST_PARTIAL;
         part_duty <= `LPD_RST_DUTY;
         part_bias <= `LPD_RST_BIAS;
         start_raw <= `LPD_RST_START;
         nline_loaded <= `LPD_RST_NLINE_EN;
         nline_cnt <= `LPD_RST_NLINE_CNT;
      end else if (cmd_write) begin
         if (take_start) begin
            // Upper two bits are don't-care
            start_raw <= cmd_byte[`LPD_START_HI:0];
         end else if (take_nline) begin
            nline_cnt <= cmd_byte[`LPD_NLINE_HI:0];
            nline_loaded <= 1'b1;
         end else if (op_osc_hi) begin
            osc_freq_low <= 1'b0;
         end else if (op_osc_lo) begin
            osc_freq_low <= 1'b1;
         end else if (op_mode_normal) begin
            partial_mode <= 1'b0;
         end else if (op_mode_partial) begin
            partial_mode <= 1'b1;
         end else if (op_release) begin
            nline_loaded <= 1'b0;
         end else if (op_duty) begin
            // Reserved codes and normal mode leave everything as is
            if (partial_mode && duty_code_ok) begin
               part_duty <= duty_clamped;
               part_bias <= bias_for_duty(duty_clamped);
            end
         end else if (op_bias) begin
            if (partial_mode && bias_code_ok) begin
               part_bias <= req_code;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Effective display settings
   // ----------------------------------------------------------------
   // The straps may move after a duty was stored, so clamp again here
   always @* begin
      if (partial_mode) begin
         eff_duty = (part_duty > pin_max_code) ? pin_max_code : part_duty;
         eff_bias = part_bias;
      end else begin
         eff_duty = pin_max_code;
         eff_bias = normal_bias_code;
      end
      eff_lines = lines_of(eff_duty);
      if ({1'b0, start_raw} >= pin_max_lines) begin
         eff_start = 6'h00;
      end else begin
         eff_start = start_raw;
      end
      // Short partial duties fall back to frame inversion
      eff_nline = nline_loaded & ~(partial_mode & (eff_duty <= `LPD_DUTY_1_17));
      area_end = {1'b0, eff_start} + eff_lines;
      // Lines past the window wrap is not modelled; area ends at line 63
      below_area = ({1'b0, scan_line} < {1'b0, eff_start});
      above_area = ({1'b0, scan_line} >= area_end);
      eff_nonselect = partial_mode & (below_area | above_area);
   end

   // ----------------------------------------------------------------
   // Output registers
   // ----------------------------------------------------------------
   always @(posedge clk) begin
      if (!rst_n) begin
         display_duty_code <= `LPD_RST_DUTY;
         display_lines <= 7'h40;
         display_bias_code <= `LPD_RST_BIAS;
         partial_start_line <= `LPD_RST_START;
         nline_inv_active <= `LPD_RST_NLINE_EN;
         nline_inv_count <= `LPD_RST_NLINE_CNT;
         com_nonselect <= 1'b0;
         value_pending <= 1'b0;
      end else begin
         display_duty_code <= eff_duty;
         display_lines <= eff_lines;
         display_bias_code <= eff_bias;
         partial_start_line <= partial_mode ? eff_start : 6'h00;
         nline_inv_active <= eff_nline;
         nline_inv_count <= nline_cnt;
         com_nonselect <= eff_nonselect;
         value_pending <= (next_state != ST_IDLE);
      end
   end

endmodule // lpd_decoder

// File: rtl/lpd_map.vh
`ifndef LPD_MAP_VH
`define LPD_MAP_VH

// ----------------------------------------------------------------
// Command opcodes
// ----------------------------------------------------------------
`define LPD_OP_OSC_HI 8'hE4
`define LPD_OP_OSC_LO 8'hE5
`define LPD_OP_MODE_NORMAL 8'h82
`define LPD_OP_MODE_PARTIAL 8'h83
`define LPD_OP_NLINE_RELEASE 8'h84
`define LPD_OP_NLINE_PREFIX 8'h85
`define LPD_OP_START_PREFIX 8'hD3
// Upper five bits shared by a group, low three carry the value
`define LPD_GRP_DUTY 5'b0_0110
`define LPD_GRP_BIAS 5'b0_0111

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define LPD_GRP_HI 7
`define LPD_GRP_LO 3
`define LPD_CODE_HI 2
`define LPD_START_HI 5
`define LPD_NLINE_HI 4

// ----------------------------------------------------------------
// Code limits
// ----------------------------------------------------------------
`define LPD_DUTY_LAST 3'h4
`define LPD_BIAS_LAST 3'h5
`define LPD_DUTY_1_17 3'h1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define LPD_RST_OSC_LOW 1'b0
`define LPD_RST_PARTIAL 1'b0
`define LPD_RST_DUTY 3'h4
`define LPD_RST_BIAS 3'h4
`define LPD_RST_START 6'h00
`define LPD_RST_NLINE_EN 1'b0
`define LPD_RST_NLINE_CNT 5'h00
`define LPD_RST_PIN_SYNC 2'h0

`endif

// File: rtl/lpd_pin_sync.v
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Three-stage pin synchroniser, change accepted once stages 2 and 3 agree
// ----------------------------------------------------------------
module lpd_pin_sync #(
   parameter WIDTH = 2
) (
   input wire clk,
   input wire rst_n,
   input wire [WIDTH-1:0] pin,
   output wire [WIDTH-1:0] level
);
   reg [WIDTH-1:0] stage1;
   reg [WIDTH-1:0] stage2;
   reg [WIDTH-1:0] stage3;
   reg [WIDTH-1:0] stable;
   genvar i;

   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         always @(posedge clk) begin
            if (!rst_n) begin
               stage1[i] <= 1'b0;
               stage2[i] <= 1'b0;
               stage3[i] <= 1'b0;
               stable[i] <= 1'b0;
            end else begin
               stage1[i] <= pin[i];
               stage2[i] <= stage1[i];
               stage3[i] <= stage2[i];
               if (stage2[i] == stage3[i]) begin
                  stable[i] <= stage3[i];
               end
            end
         end
      end
   endgenerate

   assign level = stable;
endmodule // lpd_pin_sync

// File: rtl/lpd_duty_limit.v
`timescale 1ns/10ps
`include "lpd_map.vh"
// ----------------------------------------------------------------
// Maximum duty from the strap pins and the lines each duty scans
// ----------------------------------------------------------------
module lpd_duty_limit (
   input wire [1:0] duty_pins,
   input wire [2:0] req_code,
   output wire [2:0] max_code,
   output wire [2:0] clamped_code,
   output wire [6:0] max_lines
);
   function [6:0] lines_of;
      input [2:0] code;
      begin
         case (code)
            3'h0: lines_of = 7'h08;
            3'h1: lines_of = 7'h10;
            3'h2: lines_of = 7'h20;
            3'h3: lines_of = 7'h30;
            default: lines_of = 7'h40;
         endcase
      end
   endfunction

   // Pins 00 -> 1/33, 01 -> 1/49, 10 and 11 -> 1/65
   assign max_code = (duty_pins == 2'h0) ? 3'h2 : ((duty_pins == 2'h1) ? 3'h3 : `LPD_DUTY_LAST);
   assign clamped_code = (req_code > max_code) ? max_code : req_code;
   assign max_lines = lines_of(max_code);
endmodule // lpd_duty_limit

// File: tb/lpd_decoder_assertions.sv
`timescale 1ns/10ps
module lpd_decoder_chk (
   input wire clk,
   input wire rst_n,
   input wire cmd_wr_stb,
   input wire command_data_select,
   input wire [7:0] cmd_byte,
   input wire [2:0] normal_bias_code,
   input wire osc_freq_low,
   input wire partial_mode,
   input wire [2:0] display_duty_code,
   input wire [6:0] display_lines,
   input wire [2:0] display_bias_code,
   input wire [5:0] partial_start_line,
   input wire nline_inv_active,
   input wire com_nonselect,
   input wire value_pending
);
   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------
   // Opcode decode only when no prefix is waiting for its value byte
   wire cmd = cmd_wr_stb && !command_data_select && !value_pending;
   wire [6:0] exp_lines = (display_duty_code == 3'h0) ? 7'h08 : {display_duty_code, 4'h0};

   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   osc_select_a: assert property (cmd && cmd_byte[7:1] == 7'h72 |=> osc_freq_low == $past(cmd_byte[0]))
      else $error("oscillator select wrong");
   mode_select_a: assert property (cmd && cmd_byte[7:1] == 7'h41 |=> partial_mode == $past(cmd_byte[0]))
      else $error("display mode wrong");
   pend_set_a: assert property (cmd && (cmd_byte == 8'hD3 || cmd_byte == 8'h85) |=> value_pending)
      else $error("prefix not pending");
   pend_take_a: assert property (value_pending && cmd_wr_stb && !command_data_select |=> !value_pending)
      else $error("value byte not taken");
   data_ignore_a: assert property (cmd_wr_stb && command_data_select |=> $stable({osc_freq_low, partial_mode, value_pending}))
      else $error("data write changed state");
   normal_bias_a: assert property ((!partial_mode && $stable(normal_bias_code))[*3] |-> display_bias_code == normal_bias_code)
      else $error("normal bias not followed");
   normal_area_a: assert property ((!partial_mode)[*3] |-> partial_start_line == 6'h00 && !com_nonselect)
      else $error("normal mode area wrong");
   lines_match_a: assert property (display_duty_code <= 3'h4 && display_lines == exp_lines)
      else $error("duty lines mismatch");
   short_duty_a: assert property ((partial_mode && display_duty_code < 3'h2)[*2] |-> !nline_inv_active)
      else $error("inversion on at short duty");
   release_a: assert property (cmd && cmd_byte == 8'h84 |-> ##2 !nline_inv_active)
      else $error("inversion not released");

   start_pair_c: cover property (cmd && cmd_byte == 8'hD3);
   outside_c: cover property (partial_mode && com_nonselect);
   inversion_c: cover property (nline_inv_active);
endmodule // lpd_decoder_chk

// File: tb/lpd_host_model.sv
`timescale 1ns/10ps
module lpd_host_model (
   input wire clk,
   output logic stb,
   output logic sel,
   output logic [7:0] cmd_byte
);
   initial begin
      stb = 1'b0;
      sel = 1'b0;
      cmd_byte = 8'h00;
   end
   task automatic write(input logic s, input logic [7:0] b);
      @(negedge clk);
      stb = 1'b1;
      sel = s;
      cmd_byte = b;
      @(negedge clk);
      stb = 1'b0;
      // Released bus must not keep showing the old byte
      cmd_byte = ~b;
   endtask
   task automatic pair(input logic [7:0] prefix, input logic [7:0] value);
      write(1'b0, prefix);
      write(1'b0, value);
   endtask
endmodule // lpd_host_model

// File: tb/lpd_decoder_tb.sv
`timescale 1ns/10ps
module lpd_decoder_tb;
   logic clk, rst_n;
   logic [1:0] pins;
   logic [2:0] normal_bias_code;
   logic [5:0] scan_line;
   logic [2:0] d;
   wire stb, sel, osc_freq_low, partial_mode, nline_inv_active, com_nonselect, value_pending;
   wire [7:0] cmd_byte;
   wire [2:0] display_duty_code, display_bias_code;
   wire [6:0] display_lines;
   wire [5:0] partial_start_line;
   wire [4:0] nline_inv_count;
   wire [15:0] snap = {value_pending, osc_freq_low, partial_mode, display_duty_code, display_lines, display_bias_code};
   int err_count = 0;
   int tests_run = 0;
   // Row: command, then osc, partial, duty code, bias code expected after it
   logic [15:0] rows[$] = '{16'hE5A3, 16'hE423, 16'h3223, 16'h8364, 16'h3040, 16'h3149, 16'h3252, 16'h335B,
      16'h3464, 16'h3D65, 16'h3565, 16'h3E65, 16'h3860, 16'h3760, 16'h3252, 16'h8223};
   logic [5:0] lines_q[4] = '{6'h04, 6'h05, 6'h0C, 6'h0D};
   logic outside_q[4] = '{1'b1, 1'b0, 1'b0, 1'b1};

   lpd_host_model i_host (.clk(clk), .stb(stb), .sel(sel), .cmd_byte(cmd_byte));
   lpd_decoder i_dut (.clk(clk), .rst_n(rst_n), .cmd_wr_stb(stb), .command_data_select(sel),
      .cmd_byte(cmd_byte), .max_duty_select_pin_lo(pins[0]), .max_duty_select_pin_hi(pins[1]),
      .normal_bias_code(normal_bias_code), .scan_line(scan_line), .osc_freq_low(osc_freq_low),
      .partial_mode(partial_mode), .display_duty_code(display_duty_code), .display_lines(display_lines),
      .display_bias_code(display_bias_code), .partial_start_line(partial_start_line),
      .nline_inv_active(nline_inv_active), .nline_inv_count(nline_inv_count),
      .com_nonselect(com_nonselect), .value_pending(value_pending));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
         err_count++;
      end
   endtask
   task automatic cmd(input logic [7:0] b);
      i_host.write(1'b0, b);
      repeat (3) @(negedge clk);
   endtask
   task final_report;
      $display("checks=%0d errors=%0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // ----------------------------------------------------------------
   // Sequence
   // ----------------------------------------------------------------
   initial begin
      rst_n = 1'b0;
      pins = 2'b10;
      normal_bias_code = 3'h3;
      scan_line = 6'h00;
      repeat (2) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      foreach (rows[i]) begin
         cmd(rows[i][15:8]);
         d = rows[i][5:3];
         chk(snap, {1'b0, rows[i][7:3], (d == 3'h0) ? 7'h08 : {d, 4'h0}, rows[i][2:0]});
      end
      // A data write between prefix and value must not cancel the pair
      cmd(8'h83);
      cmd(8'h30);
      i_host.write(1'b0, 8'hD3);
      i_host.write(1'b1, 8'h3F);
      cmd(8'hC5);
      chk({10'h000, partial_start_line}, 16'h0005);
      for (int k = 0; k < 4; k++) begin
         scan_line = lines_q[k];
         repeat (3) @(negedge clk);
         chk({15'h0000, com_nonselect}, {15'h0000, outside_q[k]});
      end
      cmd(8'h34);
      i_host.write(1'b0, 8'h85);
      repeat (2) @(negedge clk);
      chk({14'h0000, value_pending, nline_inv_active}, 16'h0002);
      cmd(8'hFF);
      chk({10'h000, nline_inv_active, nline_inv_count}, 16'h003F);
      cmd(8'h31);
      chk({15'h0000, nline_inv_active}, 16'h0000);
      cmd(8'h32);
      chk({15'h0000, nline_inv_active}, 16'h0001);
      cmd(8'h84);
      chk({15'h0000, nline_inv_active}, 16'h0000);
      // Strap to 1/33: held duty and start line follow the new maximum
      pins = 2'b00;
      cmd(8'h34);
      repeat (5) @(negedge clk);
      chk({6'h00, display_duty_code, display_lines}, 16'h0120);
      i_host.pair(8'hD3, 8'h28);
      repeat (3) @(negedge clk);
      chk({10'h000, partial_start_line}, 16'h0000);
      i_host.pair(8'hD3, 8'h1F);
      repeat (3) @(negedge clk);
      chk({10'h000, partial_start_line}, 16'h001F);
      // Reset in mid-run returns to higher oscillator and normal mode
      cmd(8'hE5);
      i_host.write(1'b0, 8'h85);
      rst_n = 1'b0;
      repeat (2) @(negedge clk);
      chk({9'h000, osc_freq_low, partial_mode, value_pending, nline_inv_active, com_nonselect, partial_start_line[1:0]}, 16'h0000);
      rst_n = 1'b1;
      repeat (2) @(negedge clk);
      final_report;
   end

   initial begin
      #100_000;
      err_count++;
      final_report;
   end
endmodule // lpd_decoder_tb

bind lpd_decoder lpd_decoder_chk i_chk (.clk(clk), .rst_n(rst_n), .cmd_wr_stb(cmd_wr_stb),
   .command_data_select(command_data_select), .cmd_byte(cmd_byte), .normal_bias_code(normal_bias_code),
   .osc_freq_low(osc_freq_low), .partial_mode(partial_mode), .display_duty_code(display_duty_code),
   .display_lines(display_lines), .display_bias_code(display_bias_code), .partial_start_line(partial_start_line),
   .nline_inv_active(nline_inv_active), .com_nonselect(com_nonselect), .value_pending(value_pending));
